// *** hdl/mcsf_consts.svh ***
/*
  constants for the memory controller state machine: register offsets,
  command codes, status codes, field positions and timing counts.
  assumes it is included by bare name from the modules.
*/
`ifndef MCSF_CONSTS_SVH
`define MCSF_CONSTS_SVH

`define MCSF_OFS_STATUS 12'h000
`define MCSF_OFS_STATE_CMD 12'h004
`define MCSF_OFS_DIRECT_CMD 12'h008
`define MCSF_CMD_MSB 2
`define MCSF_CMD_LSB 0
`define MCSF_CMD_RESET 3'h0
`define MCSF_CMD_GO 3'h0
`define MCSF_CMD_SLEEP 3'h1
`define MCSF_CMD_WAKEUP 3'h2
`define MCSF_CMD_PAUSE 3'h3
`define MCSF_CMD_CONFIGURE 3'h4
`define MCSF_CMD_ACTIVE_PAUSE 3'h7
`define MCSF_ST_CONFIG 2'h0
`define MCSF_ST_READY 2'h1
`define MCSF_ST_PAUSED 2'h2
`define MCSF_ST_LOWPWR 2'h3
// cycles a state change takes to settle once started
`define MCSF_SETTLE_CYCLES 4'h4
// refresh interval in cycles, reduced figure for the issue enable
`define MCSF_REFRESH_CYCLES 10'h3ff

`endif

// *** hdl/mcsf_pkg.sv ***
/*
  types for the memory controller state machine.
  assumes mcsf_consts.svh is on the include path.
*/
package mcsf_pkg;
  // one-hot controller states
  typedef enum logic [3:0] {
    MCSF_CONFIG = 4'h1,
    MCSF_READY = 4'h2,
    MCSF_PAUSED = 4'h4,
    MCSF_LOWPWR = 4'h8
  } mcsf_state_t;
endpackage

// *** hdl/mcsf_tick.sv ***
/*
  divider that gives a one-cycle enable every LEN+1 cycles while run_i is high.
  assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "mcsf_consts.svh"
module mcsf_tick
  import mcsf_pkg::*;
#(
  parameter logic [9:0] LEN = `MCSF_REFRESH_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  // count up while running, wrap on reaching the length
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run_i) begin
      cnt_nxt = 10'h000;
    end else if (cnt_r == LEN) begin
      cnt_nxt = 10'h000;
    end else begin
      cnt_nxt = cnt_r + 10'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_o = run_i && (cnt_r == LEN);
endmodule

// *** hdl/mcsf_ctrl.sv ***
/*
  memory controller state machine with its apb3 register port.
  holds the write-only state command register, the read-only state
  status, the direct command write gate and the refresh issue gate.
  assumes apb3 signals are synchronous to core_clk_i and that the
  arbiter reports when its queue is empty.
*/
`timescale 1ns/1ns
`include "mcsf_consts.svh"
// Summary of operation
// - each write of a used code to the command register moves the state machine; bits 2-0.
// - a command arriving during an unfinished change stalls pready low.
// - codes 000 go, 001 sleep, 010 wakeup, 011 pause, 100 cfg, 111 apause.
// - active pause enters paused without draining the arbiter queue.
// - no refresh commands are issued while in config state.
// - status bits 1-0 report 00 config, 01 ready, 10 paused, 11 low power.
// - direct command writes are accepted only in config or low power.
module mcsf_ctrl
  import mcsf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic queue_empty_i,
  output logic queue_hold_o,
  output logic self_refresh_o,
  output logic refresh_o,
  output logic direct_cmd_we_o,
  output logic [31:0] direct_cmd_o,
  output logic [1:0] state_o,
  output logic busy_o
);
  mcsf_state_t state_r, state_nxt;
  mcsf_state_t target_r, target_nxt;
  logic busy_r, busy_nxt;
  logic drain_r, drain_nxt;
  logic [3:0] settle_r, settle_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] dcmd_r, dcmd_nxt;
  logic dcmd_we_r, dcmd_we_nxt;
  logic access;
  logic cmd_wr;
  logic dcmd_wr;
  logic rfsh_run;
  logic rfsh_tick;
  logic [1:0] code;

  assign access = psel_i && penable_i;
  assign cmd_wr = access && pwrite_i && (paddr_i == `MCSF_OFS_STATE_CMD);
  assign dcmd_wr = access && pwrite_i && (paddr_i == `MCSF_OFS_DIRECT_CMD);

  // command write waits while an earlier change is unfinished
  assign pready_o = !(cmd_wr && busy_r);
  assign pslverr_o = 1'b0;
  assign prdata_o = prdata_r;

  // state to two-bit status code
  always_comb begin
    unique case (state_r)
      MCSF_CONFIG: code = `MCSF_ST_CONFIG;
      MCSF_READY: code = `MCSF_ST_READY;
      MCSF_PAUSED: code = `MCSF_ST_PAUSED;
      MCSF_LOWPWR: code = `MCSF_ST_LOWPWR;
      default: code = `MCSF_ST_CONFIG;
    endcase
  end

  // command decode, drain wait and settle counting
  always_comb begin
    state_nxt = state_r;
    target_nxt = target_r;
    busy_nxt = busy_r;
    drain_nxt = drain_r;
    settle_nxt = settle_r;
    cmd_nxt = cmd_r;
    if (cmd_wr && !busy_r) begin
      cmd_nxt = pwdata_i[`MCSF_CMD_MSB:`MCSF_CMD_LSB];
      busy_nxt = 1'b1;
      drain_nxt = 1'b0;
      settle_nxt = `MCSF_SETTLE_CYCLES;
      unique case (pwdata_i[`MCSF_CMD_MSB:`MCSF_CMD_LSB])
        `MCSF_CMD_GO: target_nxt = MCSF_READY;
        `MCSF_CMD_SLEEP: target_nxt = MCSF_LOWPWR;
        `MCSF_CMD_WAKEUP: target_nxt = MCSF_PAUSED;
        `MCSF_CMD_PAUSE: begin
          target_nxt = MCSF_PAUSED;
          drain_nxt = 1'b1; // plain pause waits for the arbiter queue to empty first
        end
        `MCSF_CMD_CONFIGURE: target_nxt = MCSF_CONFIG;
        `MCSF_CMD_ACTIVE_PAUSE: target_nxt = MCSF_PAUSED;
        default: begin
          target_nxt = state_r; // unused codes change nothing
          settle_nxt = 4'h1;
        end
      endcase
    end else if (busy_r) begin
      if (drain_r) begin
        // hold the change until the arbiter queue has emptied
        drain_nxt = !queue_empty_i;
      end else if (settle_r > 4'h1) begin
        settle_nxt = settle_r - 4'h1;
      end else begin
        state_nxt = target_r;
        busy_nxt = 1'b0;
        settle_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= MCSF_CONFIG;
      target_r <= MCSF_CONFIG;
      busy_r <= 1'b0;
      drain_r <= 1'b0;
      settle_r <= 4'h0;
      cmd_r <= `MCSF_CMD_RESET;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      busy_r <= busy_nxt;
      drain_r <= drain_nxt;
      settle_r <= settle_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // read data and direct command capture
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    dcmd_nxt = dcmd_r;
    dcmd_we_nxt = 1'b0;
    if (psel_i && !penable_i && !pwrite_i &&
        (paddr_i == `MCSF_OFS_STATUS)) begin
      prdata_nxt = {30'h0000_0000, code};
    end
    if (dcmd_wr && ((state_r == MCSF_CONFIG) ||
                    (state_r == MCSF_LOWPWR))) begin
      dcmd_nxt = pwdata_i;
      dcmd_we_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prdata_r <= 32'h0000_0000;
      dcmd_r <= 32'h0000_0000;
      dcmd_we_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      dcmd_r <= dcmd_nxt;
      dcmd_we_r <= dcmd_we_nxt;
    end
  end

  // refresh only runs outside config; low power uses self-refresh instead
  assign rfsh_run = (state_r == MCSF_READY) || (state_r == MCSF_PAUSED);

  mcsf_tick #(
    .LEN(`MCSF_REFRESH_CYCLES)
  ) mcsf_tick_inst (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .run_i(rfsh_run),
    .tick_o(rfsh_tick)
  );

  assign refresh_o = rfsh_tick;
  assign self_refresh_o = (state_r == MCSF_LOWPWR);
  // queue is held, not drained, in every state but ready
  assign queue_hold_o = (state_r != MCSF_READY);
  assign direct_cmd_we_o = dcmd_we_r;
  assign direct_cmd_o = dcmd_r;
  assign state_o = code;
  assign busy_o = busy_r;

  // checked against the settle counter, not the term that drives pready
  a_stall_busy: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cmd_wr && settle_r != 4'h0) |-> !pready_o)
    else $error("command write not stalled while busy");

  a_go_ready: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cmd_wr && !busy_r && pwdata_i[2:0] == 3'h0) |->
    ##5 (state_o == 2'h1))
    else $error("go did not reach ready");

  a_apause_nodrain: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (cmd_wr && !busy_r && pwdata_i[2:0] == 3'h7) |->
    ##5 (state_o == 2'h2))
    else $error("active pause waited for the queue");

  a_sleep_lowpwr: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cmd_wr && !busy_r && pwdata_i[2:0] == 3'h1) |->
    ##5 (state_o == 2'h3 && self_refresh_o))
    else $error("sleep did not reach low power");

  a_no_cfg_rfsh: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (state_o == 2'h0) |-> !refresh_o)
    else $error("refresh issued in config");

  a_status_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000) |=>
    (prdata_o[1:0] == $past(state_o) && prdata_o[31:2] == 30'h0))
    else $error("status read wrong");

  a_dcmd_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (dcmd_wr && (state_o == 2'h1 || state_o == 2'h2)) |=>
    !direct_cmd_we_o)
    else $error("direct command taken in wrong state");

  a_stable_busy: assert property (@(posedge core_clk_i) disable iff (reset_i)
    busy_o |=> (state_o == $past(state_o)) || !busy_o)
    else $error("state moved during a change");

  // a finished plain pause always lands in paused
  a_pause_done: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ($fell(busy_o) && cmd_r == 3'h3) |-> (state_o == 2'h2))
    else $error("plain pause did not reach paused");
endmodule

// *** verification/mcsf_arb_model.sv ***
/*
  behavioural arbiter queue beside the state machine.
  assumes queue_hold_o freezes draining, one entry a cycle otherwise.
*/
`timescale 1ns/1ns
module mcsf_arb_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hold_i,
  input wire logic load_i,
  input wire logic [3:0] fill_i,
  output logic empty_o
);
  logic [3:0] cnt_r;
  // held entries stay put while paused, so nothing drains then
  always_ff @(posedge core_clk_i) begin
    if (reset_i) cnt_r <= 4'h0;
    else if (load_i) cnt_r <= fill_i;
    else if (!hold_i && cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign empty_o = (cnt_r == 4'h0);
endmodule

// *** verification/memory_controller_state_fsm_tb.sv ***
/*
  self-checking bench for the state machine and its register port.
  assumes the arbiter model drives the queue empty flag.
*/
`timescale 1ns/1ns
module memory_controller_state_fsm_tb;
  logic core_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [31:0] dcmd, dv;
  logic pready, qe, qh, rf, we, busy, stl, srf, perr, load = 0;
  logic [3:0] fill = 4'h0;
  logic [1:0] st;
  logic [31:0] q[$];
  logic [2:0] codes[6] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h4, 3'h0};
  logic [31:0] exps[6] = '{32'h1, 32'h2, 32'h3, 32'h2, 32'h0, 32'h1};
  int fail_count = 0, cmp_count = 0, cyc = 0, refs = 0, wes = 0, r0, w0;
  always #2 core_clk_i = ~core_clk_i;
  mcsf_ctrl mcsf_ctrl_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .queue_empty_i(qe),
    .queue_hold_o(qh), .self_refresh_o(srf), .refresh_o(rf),
    .direct_cmd_we_o(we), .direct_cmd_o(dcmd), .state_o(st),
    .busy_o(busy));
  mcsf_arb_model mcsf_arb_model_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .hold_i(qh), .load_i(load), .fill_i(fill),
    .empty_o(qe));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb3 transfer, held until pready is seen high at an edge
  // a pready that never rises is caught by the cycle ceiling
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    stl = 0;
    @(posedge core_clk_i);
    #1 psel = 1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(posedge core_clk_i);
    #1 penable = 1;
    @(posedge core_clk_i);
    while (pready !== 1'b1) begin
      stl = 1;
      @(posedge core_clk_i);
    end
    #1 psel = 0;
    penable = 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // reserved upper bits carry random junk that must be ignored
  task cmd(input logic [2:0] c);
    logic [31:0] d;
    d = $urandom();
    d[2:0] = c;
    apb(1, 12'h004, d);
  endtask
  task settle;
    repeat (2) @(posedge core_clk_i);
    while (busy !== 1'b0) @(posedge core_clk_i);
  endtask
  // preload the arbiter model with a full queue
  task fillq;
    @(posedge core_clk_i);
    #1 load = 1;
    fill = 4'hf;
    @(posedge core_clk_i);
    #1 load = 0;
  endtask
  task win(output int r);
    r = refs;
    repeat (1100) @(posedge core_clk_i);
    r = refs - r;
  endtask
  // read results are compared against the oldest note
  always @(posedge core_clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, q.pop_front());
    end
    if (psel && penable && pready === 1'b1) chk(perr, 1'b0);
    if (rf === 1'b1) refs++;
    if (we === 1'b1) wes++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h152cf3ad));
    repeat (6) @(posedge core_clk_i);
    #1 reset_i = 0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      cmd(codes[i]);
      // the status read between commands lets each change finish
      chk(stl, 1'b0);
      rd(12'h000, i > 0 ? exps[i - 1] : 32'h0);
    end
    settle();
    rd(12'h000, 32'h1);
    $display("test command walk done");
    // a second command right behind the first must wait for it
    cmd(3'h0);
    cmd(3'h5);
    chk(stl, 1'b1);
    settle();
    rd(12'h000, 32'h1);
    // plain pause lets the queue empty before pausing
    fillq();
    cmd(3'h3);
    settle();
    chk(qe, 1'b1);
    chk(st, 2'h2);
    $display("test stall and drain done");
    cmd(3'h4);
    settle();
    win(r0);
    chk(r0, 0);
    w0 = wes;
    apb(1, 12'h008, $urandom());
    repeat (2) @(posedge core_clk_i);
    chk(wes - w0, 1);
    cmd(3'h0);
    settle();
    apb(1, 12'h008, $urandom());
    repeat (2) @(posedge core_clk_i);
    chk(wes - w0, 1);
    win(r0);
    chk(r0 > 0, 1);
    $display("test refresh and direct done");
    fillq();
    cmd(3'h7);
    settle();
    chk(qe, 1'b0);
    rd(12'h000, 32'h2);
    $display("test retained pause done");
    // power stays on and reset stays low from here, so held entries must survive
    cmd(3'h1);
    settle();
    chk(qe, 1'b0);
    chk(st, 2'h3);
    chk(srf, 1'b1);
    // memory update made from low power, not from config
    dv = $urandom();
    apb(1, 12'h008, dv);
    repeat (2) @(posedge core_clk_i);
    chk(wes - w0, 2);
    chk(dcmd, dv);
    $display("test low power update done");
    results();
  end
endmodule
